// File: rtl/fan_readout_defs.vh
/*
 * Constants for the fan speed and duty readout register bank:
 * register offsets, reset values, field positions and timing counts.
 * Assumes the includer uses the values with the widths given here.
 */
`ifndef FAN_READOUT_DEFS_VH
`define FAN_READOUT_DEFS_VH

// Register offsets
`define OFS_FAN1_COUNT_LOW 8'h28
`define OFS_FAN1_COUNT_HIGH 8'h29
`define OFS_FAN2_COUNT_LOW 8'h2a
`define OFS_FAN2_COUNT_HIGH 8'h2b
`define OFS_FAN3_COUNT_LOW 8'h2c
`define OFS_FAN3_COUNT_HIGH 8'h2d
`define OFS_FAN4_COUNT_LOW 8'h2e
`define OFS_FAN4_COUNT_HIGH 8'h2f
`define OFS_DRIVE1_DUTY 8'h30
`define OFS_DRIVE2_DUTY 8'h31
`define OFS_DRIVE3_DUTY 8'h32
`define OFS_MAKER_ID 8'h3e
`define OFS_VERSION 8'h3f

// Reset values
`define RST_SPEED_COUNT 16'hffff
`define RST_SPEED_HIGH 8'hff
`define RST_DRIVE_DUTY 8'hff
`define DUTY_ZERO 8'h00
`define DUTY_FULL 8'hff

// Version register fields
`define VERSION_MSB 7
`define VERSION_LSB 4
`define STEP_MSB 3
`define STEP_LSB 0

// Timing: clock rate, tach reference rate and refresh interval
`define CLK_HZ 50000000
`define REF_HZ 90000
`define REF_DIV ((`CLK_HZ + `REF_HZ / 2) / `REF_HZ)
`define REFRESH_MS 1000
`define REFRESH_CYCLES ((`CLK_HZ / 1000) * `REFRESH_MS)

`endif

// File: rtl/fan_speed_duty_readout_regs.v
/*
 * Fan speed and duty readout register bank of a health monitor.
 * Measures four tach inputs against a 90 kHz reference, publishes counts
 * once per refresh interval, and holds three fan drive duty registers.
 * Assumes all inputs are synchronous to clk, and that mode, spin-up and
 * automatic duty come from the fan control logic outside this block.
 */
`include "fan_readout_defs.vh"
`default_nettype none

module fan_speed_duty_readout_regs #(
    parameter NUM_FANS = 4,
    parameter NUM_DRIVES = 3,
    parameter REFRESH_CYCLES = `REFRESH_CYCLES,
    parameter [7:0] MAKER_ID = 8'h5a,        // Arbitrary value
    parameter [3:0] MONITOR_VERSION = 4'h3,  // Arbitrary value
    parameter [3:0] STEPPING = 4'h2          // Arbitrary value
) (
    // Clock and reset
    input wire clk,
    input wire rst,
    // Register port
    input wire [7:0] addr,
    input wire rd_en,
    input wire wr_en,
    input wire [7:0] wdata,
    output reg [7:0] rdata_ff,
    output reg rd_valid_ff,
    // Fan tach inputs and revolution select
    input wire [NUM_FANS-1:0] tach_in,
    input wire [NUM_FANS-1:0] pulses_per_revolution_select,
    // Fan control state from the mode logic
    input wire [NUM_DRIVES-1:0] manual_mode,
    input wire [NUM_DRIVES-1:0] spin_up,
    input wire [NUM_DRIVES*8-1:0] applied_duty,
    // Drive outputs
    output wire [NUM_DRIVES*8-1:0] drive_duty,
    output reg [NUM_DRIVES-1:0] fan_drive_output
);

    localparam [31:0] REF_DIV_CYC = `REF_DIV;
    localparam [31:0] REFRESH_CYC = REFRESH_CYCLES;

    // Tach channel index of an address, valid only inside the tach range
    function [1:0] tach_index;
        input [7:0] a;
        reg [7:0] d;
        begin
            d = a - `OFS_FAN1_COUNT_LOW;
            tach_index = d[2:1];
        end
    endfunction

    function is_tach;
        input [7:0] a;
        begin
            is_tach = (a >= `OFS_FAN1_COUNT_LOW) && (a <= `OFS_FAN4_COUNT_HIGH);
        end
    endfunction

    // 90 kHz reference enable, one clock wide
    reg [15:0] ref_div_ff;
    reg ref_tick_ff;
    always @(posedge clk) begin
        if (rst) begin
            ref_div_ff <= 16'h0000;
            ref_tick_ff <= 1'b0;
        end else if (ref_div_ff == REF_DIV_CYC[15:0] - 16'h0001) begin
            ref_div_ff <= 16'h0000;
            ref_tick_ff <= 1'b1;
        end else begin
            ref_div_ff <= ref_div_ff + 16'h0001;
            ref_tick_ff <= 1'b0;
        end
    end

    // Refresh enable; wide counter so long intervals fit.
    // The interval is a parameter so a bench can shorten it; a real
    // part keeps the one second default or readings go stale too fast.
    // once per second
    reg [31:0] refresh_cnt_ff;
    reg refresh_tick_ff;
    always @(posedge clk) begin
        if (rst) begin
            refresh_cnt_ff <= 32'h00000000;
            refresh_tick_ff <= 1'b0;
        end else if (refresh_cnt_ff == REFRESH_CYC - 32'h00000001) begin
            refresh_cnt_ff <= 32'h00000000;
            refresh_tick_ff <= 1'b1;
        end else begin
            refresh_cnt_ff <= refresh_cnt_ff + 32'h00000001;
            refresh_tick_ff <= 1'b0;
        end
    end

    wire [NUM_FANS*16-1:0] speed_flat;

    genvar f;
    generate
        // One measuring channel per fan. Each times whole revolutions in
        // reference ticks and keeps the last capture until the refresh
        // tick publishes it; a fan with no full turn publishes all ones.
        for (f = 0; f < NUM_FANS; f = f + 1) begin : g_tach
            reg tach_prev_ff;
            reg half_ff;
            reg armed_ff;
            reg seen_ff;
            reg [15:0] run_cnt_ff;
            reg [15:0] capt_ff;
            reg [15:0] speed_ff;
            wire rise = tach_in[f] & ~tach_prev_ff;
            // one or two pulses per turn
            wire rev_done = rise & (~pulses_per_revolution_select[f] | half_ff);

            // Revolution timing in reference ticks, saturating at all ones
            // count reference per revolution
            always @(posedge clk) begin
                if (rst) begin
                    tach_prev_ff <= 1'b0;
                    half_ff <= 1'b0;
                    armed_ff <= 1'b0;
                    seen_ff <= 1'b0;
                    run_cnt_ff <= 16'h0000;
                    capt_ff <= `RST_SPEED_COUNT;
                end else begin
                    tach_prev_ff <= tach_in[f];
                    if (rise)
                        half_ff <= pulses_per_revolution_select[f] & ~half_ff;
                    if (rev_done) begin
                        // First boundary only starts timing; partial turn discarded
                        armed_ff <= 1'b1;
                        run_cnt_ff <= 16'h0000;
                        if (armed_ff) begin
                            capt_ff <= run_cnt_ff;
                        end
                    end else if (ref_tick_ff && run_cnt_ff != 16'hffff) begin
                        run_cnt_ff <= run_cnt_ff + 16'h0001;
                    end
                    // New revolution wins over the refresh clear
                    if (rev_done && armed_ff)
                        seen_ff <= 1'b1;
                    else if (refresh_tick_ff)
                        seen_ff <= 1'b0;
                end
            end

            // Published count, all ones after reset or without a full turn
            // stopped reads all ones
            always @(posedge clk) begin
                if (rst)
                    speed_ff <= `RST_SPEED_COUNT;
                else if (refresh_tick_ff)
                    speed_ff <= seen_ff ? capt_ff : `RST_SPEED_COUNT;
            end
            assign speed_flat[f*16 +: 16] = speed_ff;
        end
    endgenerate

    // Free-running PWM phase shared by all drive outputs.
    // A 256 clock period keeps the compare a plain 8 bit one; the cost
    // is a fixed PWM frequency tied to the clock rate.
    reg [7:0] pwm_phase_ff;
    always @(posedge clk) begin
        if (rst)
            pwm_phase_ff <= 8'h00;
        else
            pwm_phase_ff <= pwm_phase_ff + 8'h01;
    end

    wire [NUM_DRIVES*8-1:0] duty_read;

    genvar d;
    generate
        for (d = 0; d < NUM_DRIVES; d = d + 1) begin : g_drive
            reg [7:0] manual_duty_ff;
            localparam integer MY_IDX = `OFS_DRIVE1_DUTY + d;
            wire [7:0] my_ofs = MY_IDX[7:0];
            wire [7:0] eff = manual_mode[d] ? manual_duty_ff : applied_duty[d*8 +: 8];

            // Manual duty store; write dropped outside manual mode
            // manual write sets duty
            always @(posedge clk) begin
                if (rst)
                    manual_duty_ff <= `RST_DRIVE_DUTY;
                else if (wr_en && addr == my_ofs && manual_mode[d])
                    manual_duty_ff <= wdata;
            end

            assign duty_read[d*8 +: 8] = (!manual_mode[d] && spin_up[d]) ? `DUTY_ZERO : eff;
            assign drive_duty[d*8 +: 8] = eff;

            always @(posedge clk) begin
                if (rst)
                    fan_drive_output[d] <= 1'b1;
                else
                    fan_drive_output[d] <= (eff == `DUTY_FULL) || (pwm_phase_ff < eff);
            end
        end
    endgenerate

    // Shared high-byte latch
    reg [7:0] high_latch_ff;
    reg [7:0] nxt_rdata;
    reg [15:0] sel_speed;

    // Read decode; unmapped offsets read zero
    // four tach channels
    always @* begin
        sel_speed = speed_flat[tach_index(addr)*16 +: 16];
        nxt_rdata = 8'h00;
        case (addr)
            `OFS_FAN1_COUNT_LOW,
            `OFS_FAN2_COUNT_LOW,
            `OFS_FAN3_COUNT_LOW,
            `OFS_FAN4_COUNT_LOW: begin
                // Low byte straight from the published count
                nxt_rdata = sel_speed[7:0];
            end
            `OFS_FAN1_COUNT_HIGH,
            `OFS_FAN2_COUNT_HIGH,
            `OFS_FAN3_COUNT_HIGH,
            `OFS_FAN4_COUNT_HIGH: begin
                nxt_rdata = high_latch_ff;
            end
            `OFS_DRIVE1_DUTY: begin
                nxt_rdata = duty_read[7:0];
            end
            `OFS_DRIVE2_DUTY: begin
                nxt_rdata = duty_read[15:8];
            end
            `OFS_DRIVE3_DUTY: begin
                nxt_rdata = duty_read[23:16];
            end
            `OFS_MAKER_ID: begin
                nxt_rdata = MAKER_ID;
            end
            `OFS_VERSION: begin
                nxt_rdata[`VERSION_MSB:`VERSION_LSB] = MONITOR_VERSION;
                nxt_rdata[`STEP_MSB:`STEP_LSB] = STEPPING;
            end
            default: begin
                nxt_rdata = 8'h00;
            end
        endcase
    end

    // Read data and valid flag, one cycle after the request
    always @(posedge clk) begin
        if (rst) begin
            rdata_ff <= 8'h00;
            rd_valid_ff <= 1'b0;
        end else begin
            rd_valid_ff <= rd_en;
            if (rd_en)
                rdata_ff <= nxt_rdata;
        end
    end

    // Shared high-byte latch, caught with the low byte read.
    // One latch serves all four channels, so a low read of another
    // channel before the high read overwrites it; software must pair them.
    // The latch keeps a refresh between the two reads from tearing a count.
    // low read latches high
    always @(posedge clk) begin
        if (rst)
            high_latch_ff <= `RST_SPEED_HIGH;
        else if (rd_en && is_tach(addr) && !addr[0])
            high_latch_ff <= sel_speed[15:8];
    end

endmodule

`default_nettype wire

// File: test/fan_readout_props.sv
/* Assertions for the fan readout register bank.
   Bound to the bank; sees its ports only, single clock. */
`default_nettype none
module fan_readout_props #(
    parameter [7:0] MAKER_ID = 8'h5a,
    parameter [3:0] MONITOR_VERSION = 4'h3,
    parameter [3:0] STEPPING = 4'h2
) (
    // Clock and register port
    input wire logic clk,
    input wire logic rst,
    input wire logic [7:0] addr,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata_ff,
    input wire logic rd_valid_ff,
    // Fan control and drive
    input wire logic [2:0] manual_mode,
    input wire logic [2:0] spin_up,
    input wire logic [23:0] applied_duty,
    input wire logic [23:0] drive_duty,
    input wire logic [2:0] fan_drive_output
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Read data only moves on a read
    property p_hold; !rd_en |=> $stable(rdata_ff); endproperty
    a_hold: assert property (p_hold) else $error("rdata moved without read");
    property p_id; rd_en && addr == 8'h3e |=> rd_valid_ff && rdata_ff == MAKER_ID; endproperty
    a_id: assert property (p_id) else $error("maker id wrong");
    property p_ver; rd_en && addr == 8'h3f |=> rdata_ff == {MONITOR_VERSION, STEPPING};
    endproperty
    a_ver: assert property (p_ver) else $error("version wrong");
    // Duty path per mode
    property p_auto; !manual_mode[0] |-> drive_duty[7:0] == applied_duty[7:0]; endproperty
    a_auto: assert property (p_auto) else $error("auto duty not applied");
    property p_man; manual_mode[0] && wr_en && addr == 8'h30 ##1 manual_mode[0]
        |-> drive_duty[7:0] == $past(wdata); endproperty
    a_man: assert property (p_man) else $error("manual write lost");
    property p_spin; rd_en && addr == 8'h31 && !manual_mode[1] && spin_up[1]
        |=> rdata_ff == 8'h00; endproperty
    a_spin: assert property (p_spin) else $error("spin-up duty not zero");
    property p_dread; rd_en && addr == 8'h32 && (manual_mode[2] || !spin_up[2])
        |=> rdata_ff == $past(drive_duty[23:16]); endproperty
    a_dread: assert property (p_dread) else $error("duty readback wrong");
    // Boundary duties give a flat output
    property p_off; (drive_duty[7:0] == 8'h00) [*2] |-> !fan_drive_output[0]; endproperty
    a_off: assert property (p_off) else $error("zero duty drives high");
    property p_full; (drive_duty[15:8] == 8'hff) [*2] |-> fan_drive_output[1]; endproperty
    a_full: assert property (p_full) else $error("full duty drives low");
    c_pair: cover property (rd_en && addr == 8'h2a ##2 rd_en && addr == 8'h2b);
    c_man: cover property (manual_mode[0] && wr_en && addr == 8'h30);
    c_spin: cover property (rd_en && addr == 8'h31 && spin_up[1] && !manual_mode[1]);
endmodule
bind fan_speed_duty_readout_regs fan_readout_props #(.MAKER_ID(MAKER_ID),
    .MONITOR_VERSION(MONITOR_VERSION), .STEPPING(STEPPING)) fan_readout_props_inst (
    .clk(clk), .rst(rst), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wdata(wdata),
    .rdata_ff(rdata_ff), .rd_valid_ff(rd_valid_ff), .manual_mode(manual_mode),
    .spin_up(spin_up), .applied_duty(applied_duty), .drive_duty(drive_duty),
    .fan_drive_output(fan_drive_output));
`default_nettype wire

// File: test/tb.sv
/* Self-checking bench for the fan readout register bank.
   Drives the register port and tach inputs at falling edges; short refresh. */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID = 8'ha7; // Arbitrary value
    logic clk = 0, rst = 1, rd_en = 0, wr_en = 0, run2 = 1, rd_valid_ff;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata_ff;
    logic [3:0] tach_in = 4'h0, ppr_sel = 4'h4;
    logic [2:0] manual_mode = 3'h0, spin_up = 3'h0, fan_drive_output;
    logic [23:0] applied_duty = 24'h123456, drive_duty;
    int failures = 0, total_checks = 0, tick = 0, hi = 0;
    fan_speed_duty_readout_regs #(.REFRESH_CYCLES(20000), .MAKER_ID(ID),
        .MONITOR_VERSION(4'h4), .STEPPING(4'h5)) fan_speed_duty_readout_regs_inst (
        .clk(clk), .rst(rst), .addr(addr), .rd_en(rd_en), .wr_en(wr_en), .wdata(wdata),
        .rdata_ff(rdata_ff), .rd_valid_ff(rd_valid_ff), .tach_in(tach_in),
        .pulses_per_revolution_select(ppr_sel), .manual_mode(manual_mode),
        .spin_up(spin_up), .applied_duty(applied_duty), .drive_duty(drive_duty),
        .fan_drive_output(fan_drive_output));
    initial forever #10 clk = ~clk;
    // Fan2 one pulse per 11120 clk, fan3 two; whole multiple of 556 gives exactly 20
    always @(negedge clk) begin
        tick <= tick + 1;
        tach_in[1] <= run2 && (tick % 11120) < 50;
        tach_in[2] <= (tick % 5560) < 50;
    end
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] seen);
        total_checks++;
        if (seen !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk);
        addr = a;
        rd_en = 1;
        @(negedge clk);
        rd_en = 0;
        chk("rd_valid_ff", 8'h01, {7'h00, rd_valid_ff});
        chk($sformatf("reg %h", a), exp, rdata_ff);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr_en = 1;
        @(negedge clk);
        wr_en = 0;
    endtask
    task give_verdict;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Tests need about 85500 cycles; give up at 95000
    initial begin
        #1900000;
        failures++;
        give_verdict();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst = 0;
        for (int a = 8'h28; a < 8'h30; a++) rd(a[7:0], 8'hff);
        $display("test tach_reset done");
        // Read-only places ignore writes; unmapped reads zero
        wr(8'h3e, 8'h00);
        wr(8'h3f, 8'h00);
        rd(8'h3e, ID);
        rd(8'h3f, 8'h45);
        rd(8'h50, 8'h00);
        wr(8'h30, 8'h99);
        rd(8'h30, 8'h56);
        rd(8'h32, 8'h12);
        spin_up = 3'b010;
        rd(8'h31, 8'h00);
        $display("test auto_duty done");
        // Manual mode wins over spin-up; boundary duties
        manual_mode = 3'b111;
        rd(8'h30, 8'hff);
        wr(8'h30, 8'h00);
        wr(8'h31, 8'hff);
        wr(8'h32, 8'ha5);
        rd(8'h30, 8'h00);
        rd(8'h31, 8'hff);
        rd(8'h32, 8'ha5);
        chk("drive_duty3", 8'ha5, drive_duty[23:16]);
        repeat (256) begin
            @(negedge clk);
            hi += fan_drive_output[2];
        end
        chk("drive3 high cycles", 8'ha5, hi[7:0]);
        manual_mode = 3'h0;
        spin_up = 3'h0;
        $display("test manual_duty done");
        // Counts after refresh; shared latch across channels
        repeat (45000) @(negedge clk);
        rd(8'h2a, 8'h14);
        rd(8'h2b, 8'h00);
        rd(8'h2c, 8'h14);
        rd(8'h2d, 8'h00);
        rd(8'h28, 8'hff);
        rd(8'h29, 8'hff);
        rd(8'h2a, 8'h14);
        rd(8'h2e, 8'hff);
        rd(8'h2b, 8'hff);
        $display("test tach_counts done");
        // Stopped fan shows all ones after later refreshes
        run2 = 0;
        repeat (40000) @(negedge clk);
        rd(8'h2a, 8'hff);
        rd(8'h2b, 8'hff);
        $display("test tach_refresh done");
        give_verdict();
    end
endmodule
`default_nettype wire
